// ---- verilog/fqt_pkg.sv ----
package fqt_pkg;

  // Word address width of the read path
  localparam int FQT_ADDR_W = 27;

  // Table span and length in entries
  localparam logic [7:0] FQT_FIRST_OFF = 8'h1B;
  localparam logic [7:0] FQT_LAST_OFF  = 8'h38;
  localparam int         FQT_TABLE_LEN = 30;
  localparam logic [4:0] FQT_LAST_IDX  = 5'h1D;
  localparam logic [7:0] FQT_HIGH_BYTE = 8'h00;

  // Register offsets and fixed values
  localparam logic [7:0]  FQT_CORE_SUPPLY_MIN_VOLTAGE_OFF     = 8'h1B;
  localparam logic [7:0]  FQT_CORE_SUPPLY_MIN_VOLTAGE_RST     = 8'h23;
  localparam logic [7:0]  FQT_CORE_SUPPLY_MAX_VOLTAGE_OFF     = 8'h1C;
  localparam logic [7:0]  FQT_CORE_SUPPLY_MAX_VOLTAGE_RST     = 8'h36;
  localparam logic [7:0]  FQT_PROGRAM_SUPPLY_MIN_VOLTAGE_OFF  = 8'h1D;
  localparam logic [7:0]  FQT_PROGRAM_SUPPLY_MIN_VOLTAGE_RST  = 8'h85;
  localparam logic [7:0]  FQT_PROGRAM_SUPPLY_MAX_VOLTAGE_OFF  = 8'h1E;
  localparam logic [7:0]  FQT_PROGRAM_SUPPLY_MAX_VOLTAGE_RST  = 8'h95;
  localparam logic [7:0]  FQT_WORD_PROGRAM_TYP_TIMEOUT_OFF    = 8'h1F;
  localparam logic [7:0]  FQT_WORD_PROGRAM_TYP_TIMEOUT_RST    = 8'h09;
  localparam logic [7:0]  FQT_BUFFER_WRITE_TYP_TIMEOUT_OFF    = 8'h20;
  localparam logic [7:0]  FQT_BUFFER_WRITE_TYP_TIMEOUT_RST    = 8'h0A;
  localparam logic [7:0]  FQT_BLOCK_ERASE_TYP_TIMEOUT_OFF     = 8'h21;
  localparam logic [7:0]  FQT_BLOCK_ERASE_TYP_TIMEOUT_RST     = 8'h0A;
  localparam logic [7:0]  FQT_CHIP_ERASE_TYP_TIMEOUT_OFF      = 8'h22;
  localparam logic [7:0]  FQT_CHIP_ERASE_TYP_TIMEOUT_RST      = 8'h00;
  localparam logic [7:0]  FQT_WORD_PROGRAM_MAX_MULTIPLIER_OFF = 8'h23;
  localparam logic [7:0]  FQT_WORD_PROGRAM_MAX_MULTIPLIER_RST = 8'h01;
  localparam logic [7:0]  FQT_BUFFER_WRITE_MAX_MULTIPLIER_OFF = 8'h24;
  localparam logic [7:0]  FQT_BUFFER_WRITE_MAX_MULTIPLIER_RST = 8'h02;
  localparam logic [7:0]  FQT_BLOCK_ERASE_MAX_MULTIPLIER_OFF  = 8'h25;
  localparam logic [7:0]  FQT_BLOCK_ERASE_MAX_MULTIPLIER_RST  = 8'h02;
  localparam logic [7:0]  FQT_CHIP_ERASE_MAX_MULTIPLIER_OFF   = 8'h26;
  localparam logic [7:0]  FQT_CHIP_ERASE_MAX_MULTIPLIER_RST   = 8'h00;
  localparam logic [7:0]  FQT_CAPACITY_EXPONENT_OFF           = 8'h27;
  localparam logic [7:0]  FQT_BUS_WIDTH_CAPABILITY_OFF        = 8'h28;
  localparam logic [15:0] FQT_BUS_WIDTH_CAPABILITY_RST        = 16'h0001;
  localparam logic [7:0]  FQT_WRITE_BUFFER_SIZE_EXPONENT_OFF  = 8'h2A;
  localparam logic [15:0] FQT_WRITE_BUFFER_SIZE_EXPONENT_RST  = 16'h000A;
  localparam logic [7:0]  FQT_ERASE_REGION_COUNT_OFF          = 8'h2C;
  localparam logic [7:0]  FQT_ERASE_REGION_ONE_DESCRIPTOR_OFF = 8'h2D;
  localparam logic [7:0]  FQT_ERASE_REGION_TWO_DESCRIPTOR_OFF = 8'h31;
  localparam logic [7:0]  FQT_RESERVED_REGION_DESCRIPTOR_OFF  = 8'h35;
  localparam logic [31:0] FQT_RESERVED_REGION_DESCRIPTOR_RST  = 32'h00000000;

  // Variant dependent geometry values
  localparam logic [7:0]  FQT_CAP_512M        = 8'h1A;
  localparam logic [7:0]  FQT_CAP_1G_2G       = 8'h1B;
  localparam logic [7:0]  FQT_REGIONS_ASYM    = 8'h02;
  localparam logic [7:0]  FQT_REGIONS_SYM     = 8'h01;
  localparam logic [15:0] FQT_MAIN_CNT_512_A  = 16'h01FE;
  localparam logic [15:0] FQT_MAIN_CNT_512_S  = 16'h01FF;
  localparam logic [15:0] FQT_MAIN_CNT_1G_A   = 16'h03FE;
  localparam logic [15:0] FQT_MAIN_CNT_BIG_S  = 16'h03FF;
  localparam logic [15:0] FQT_MAIN_SIZE       = 16'h0200;
  localparam logic [15:0] FQT_PARAM_CNT       = 16'h0003;
  localparam logic [15:0] FQT_PARAM_SIZE      = 16'h0080;

  // Density and block layout variants
  typedef enum {FQT_DENS_512M, FQT_DENS_1G, FQT_DENS_2G} fqt_density_t;
  typedef enum {FQT_LAY_TOP, FQT_LAY_BOTTOM, FQT_LAY_SYM} fqt_layout_t;

  // Region descriptor: size in 256 byte units over count minus one
  typedef struct packed {
    logic [15:0] size;
    logic [15:0] count;
  } fqt_region_t;

  // Read request and answer of the query read path
  typedef struct packed {
    logic                  valid;
    logic [FQT_ADDR_W-1:0] addr;
  } fqt_req_t;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] data;
  } fqt_rsp_t;

endpackage

// ---- verilog/fqt_rom.sv ----
module fqt_rom
  import fqt_pkg::*;
#(
  parameter fqt_density_t density = FQT_DENS_512M,
  parameter fqt_layout_t  layout  = FQT_LAY_TOP
) (
  input  wire logic [4:0] idx,
  output logic      [7:0] data
);

  fqt_region_t main_r;   // Main block region
  fqt_region_t param_r;  // Small block region
  fqt_region_t one_r;    // Lower addressed region
  fqt_region_t two_r;    // Higher addressed region
  logic [7:0]  cap;      // Capacity exponent
  logic [7:0]  regions;  // Region count
  logic [7:0]  off;      // Word offset of entry
  logic        sym;      // Symmetrical layout
  logic [1:0]  lane;     // Byte within a descriptor

  // Geometry chosen by variant
  always_comb begin
    sym = (layout == FQT_LAY_SYM) || (density == FQT_DENS_2G);
    cap = (density == FQT_DENS_512M) ? FQT_CAP_512M : FQT_CAP_1G_2G;
    regions = sym ? FQT_REGIONS_SYM : FQT_REGIONS_ASYM;
    main_r.size = FQT_MAIN_SIZE;
    if (density == FQT_DENS_512M) begin
      main_r.count = sym ? FQT_MAIN_CNT_512_S : FQT_MAIN_CNT_512_A;
    end else if (density == FQT_DENS_1G) begin
      main_r.count = sym ? FQT_MAIN_CNT_BIG_S : FQT_MAIN_CNT_1G_A;
    end else begin
      main_r.count = FQT_MAIN_CNT_BIG_S;
    end
    param_r.size  = FQT_PARAM_SIZE;
    param_r.count = FQT_PARAM_CNT;
    // Lower region first, upper second
    if (sym) begin
      one_r = main_r;
      two_r = '0;
    end else if (layout == FQT_LAY_TOP) begin
      one_r = main_r;
      two_r = param_r;
    end else begin
      one_r = param_r;
      two_r = main_r;
    end
  end

  // Byte select by word offset
  always_comb begin
    off = FQT_FIRST_OFF + {3'b000, idx};
    // Two bit wrap keeps the last byte at lane three
    lane = off[1:0] - 2'd1;
    data = 8'h00;
    unique case (off)
      FQT_CORE_SUPPLY_MIN_VOLTAGE_OFF:     data = FQT_CORE_SUPPLY_MIN_VOLTAGE_RST;
      FQT_CORE_SUPPLY_MAX_VOLTAGE_OFF:     data = FQT_CORE_SUPPLY_MAX_VOLTAGE_RST;
      FQT_PROGRAM_SUPPLY_MIN_VOLTAGE_OFF:  data = FQT_PROGRAM_SUPPLY_MIN_VOLTAGE_RST;
      FQT_PROGRAM_SUPPLY_MAX_VOLTAGE_OFF:  data = FQT_PROGRAM_SUPPLY_MAX_VOLTAGE_RST;
      FQT_WORD_PROGRAM_TYP_TIMEOUT_OFF:    data = FQT_WORD_PROGRAM_TYP_TIMEOUT_RST;
      FQT_BUFFER_WRITE_TYP_TIMEOUT_OFF:    data = FQT_BUFFER_WRITE_TYP_TIMEOUT_RST;
      FQT_BLOCK_ERASE_TYP_TIMEOUT_OFF:     data = FQT_BLOCK_ERASE_TYP_TIMEOUT_RST;
      FQT_CHIP_ERASE_TYP_TIMEOUT_OFF:      data = FQT_CHIP_ERASE_TYP_TIMEOUT_RST;
      FQT_WORD_PROGRAM_MAX_MULTIPLIER_OFF: data = FQT_WORD_PROGRAM_MAX_MULTIPLIER_RST;
      FQT_BUFFER_WRITE_MAX_MULTIPLIER_OFF: data = FQT_BUFFER_WRITE_MAX_MULTIPLIER_RST;
      FQT_BLOCK_ERASE_MAX_MULTIPLIER_OFF:  data = FQT_BLOCK_ERASE_MAX_MULTIPLIER_RST;
      FQT_CHIP_ERASE_MAX_MULTIPLIER_OFF:   data = FQT_CHIP_ERASE_MAX_MULTIPLIER_RST;
      FQT_CAPACITY_EXPONENT_OFF:           data = cap;
      FQT_BUS_WIDTH_CAPABILITY_OFF:        data = FQT_BUS_WIDTH_CAPABILITY_RST[7:0];
      FQT_BUS_WIDTH_CAPABILITY_OFF + 8'h01: data = FQT_BUS_WIDTH_CAPABILITY_RST[15:8];
      FQT_WRITE_BUFFER_SIZE_EXPONENT_OFF:  data = FQT_WRITE_BUFFER_SIZE_EXPONENT_RST[7:0];
      FQT_WRITE_BUFFER_SIZE_EXPONENT_OFF + 8'h01: data = FQT_WRITE_BUFFER_SIZE_EXPONENT_RST[15:8];
      FQT_ERASE_REGION_COUNT_OFF:          data = regions;
      default: begin
        // Descriptor bytes, least significant first
        if (off >= FQT_RESERVED_REGION_DESCRIPTOR_OFF) begin
          data = FQT_RESERVED_REGION_DESCRIPTOR_RST[8*lane+:8];
        end else if (off >= FQT_ERASE_REGION_TWO_DESCRIPTOR_OFF) begin
          data = two_r[8*lane+:8];
        end else if (off >= FQT_ERASE_REGION_ONE_DESCRIPTOR_OFF) begin
          data = one_r[8*lane+:8];
        end else begin
          data = 8'h00;
        end
      end
    endcase
  end

endmodule // fqt_rom

// ---- verilog/fqt_query_table.sv ----
module fqt_query_table
  import fqt_pkg::*;
#(
  parameter fqt_density_t density = FQT_DENS_512M,
  parameter fqt_layout_t  layout  = FQT_LAY_TOP
) (
  input  wire logic     core_clk,
  input  wire logic     nrst,
  input  wire logic     query_mode,
  input  wire fqt_req_t req,
  output fqt_rsp_t      rsp,
  output logic          table_ready
);

  // Loader states
  typedef enum {FQT_ST_LOAD, FQT_ST_READY} fqt_state_t;

  fqt_state_t state;          // Loader state
  logic [4:0] load_idx;       // Entry being copied
  logic [7:0] rom_byte;       // Constant source byte
  logic [7:0] table_q [FQT_TABLE_LEN]; // Table storage
  logic       in_range;       // Address inside table
  logic [7:0] diff;           // Offset from table start
  logic [4:0] rd_idx;         // Storage index of read
  logic       take;           // Request is answered

  // Test for an address that falls in the table
  function automatic logic fqt_in_table(
    input logic [FQT_ADDR_W-1:0] a
  );
    logic upper_zero;
    upper_zero = (a[FQT_ADDR_W-1:8] == '0);
    return upper_zero
      && (a[7:0] >= FQT_FIRST_OFF)
      && (a[7:0] <= FQT_LAST_OFF);
  endfunction

  // Constant contents for the chosen variant
  fqt_rom #(
    .density (density),
    .layout  (layout)
  ) u_rom (
    .idx  (load_idx),
    .data (rom_byte)
  );

  // Loader steps through every entry once
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= FQT_ST_LOAD;
    end else begin
      unique case (state)
        // Copy until last entry written
        FQT_ST_LOAD: begin
          if (load_idx == FQT_LAST_IDX) begin
            state <= FQT_ST_READY;
          end
        end
        // Table stays fixed
        FQT_ST_READY: begin
          state <= FQT_ST_READY;
        end
      endcase
    end
  end

  // Load index advances while loading
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      load_idx <= 5'h00;
    end else if (state == FQT_ST_LOAD) begin
      if (load_idx != FQT_LAST_IDX) begin
        load_idx <= load_idx + 5'h01;
      end
    end
  end

  // Storage written once per entry during load
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < FQT_TABLE_LEN; i++) begin
        table_q[i] <= 8'h00;
      end
    end else if (state == FQT_ST_LOAD) begin
      for (int i = 0; i < FQT_TABLE_LEN; i++) begin
        if (load_idx == 5'(i)) begin
          table_q[i] <= rom_byte;
        end
      end
    end
  end

  // Ready flag follows the loader
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      table_ready <= 1'b0;
    end else begin
      table_ready <= (state == FQT_ST_READY);
    end
  end

  // Address decode of the incoming read
  always_comb begin
    in_range = fqt_in_table(req.addr);
    diff = req.addr[7:0] - FQT_FIRST_OFF;
    rd_idx = diff[4:0];
    // Answer only query reads once loaded
    take = req.valid && query_mode
      && (state == FQT_ST_READY);
  end

  // Answer register, one cycle after request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= take;
      if (take) begin
        rsp.hit <= in_range;
        // High byte is always zero
        rsp.data[15:8] <= FQT_HIGH_BYTE;
        if (in_range) begin
          rsp.data[7:0] <= table_q[rd_idx];
        end else begin
          // Outside the table reads zero
          rsp.data[7:0] <= 8'h00;
        end
      end
    end
  end

endmodule // fqt_query_table

// ---- bench/fqt_query_table_props.sv ----
module fqt_query_table_props
  import fqt_pkg::*;
(
  input wire logic     core_clk,
  input wire logic     nrst,
  input wire logic     query_mode,
  input wire fqt_req_t req,
  input wire fqt_rsp_t rsp,
  input wire logic     table_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // One clock domain, reset disables all checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_answer_taken: assert property (req.valid && query_mode && table_ready |=> rsp.valid)
    else $error("taken read got no answer");
  chk_no_request: assert property (!(req.valid && query_mode) |=> !rsp.valid)
    else $error("answer without a taken read");
  chk_upper_zero: assert property (rsp.data[15:8] == 8'h00)
    else $error("upper data byte not zero");
  chk_hit_range: assert property (rsp.valid |-> rsp.hit == ($past(req.addr) inside {[27'h1B:27'h38]}))
    else $error("hit flag wrong for address");
  chk_miss_zero: assert property (rsp.valid && !rsp.hit |-> rsp.data == 16'h0000)
    else $error("miss answer not zero");
  chk_data_hold: assert property (!rsp.valid |-> $stable(rsp.data) && $stable(rsp.hit))
    else $error("answer changed between reads");
  chk_core_volt: assert property (rsp.valid && $past(req.addr) == 27'h1B |-> rsp.data == 16'h0023)
    else $error("core minimum voltage wrong");
  chk_chip_erase: assert property (
    rsp.valid && $past(req.addr) inside {27'h22, 27'h26} |-> rsp.data == 16'h0000)
    else $error("chip erase field not zero");
  chk_reserved_zero: assert property (
    rsp.valid && $past(req.addr) inside {[27'h35:27'h38]} |-> rsp.data == 16'h0000)
    else $error("reserved descriptor not zero");
  chk_ready_stays: assert property (table_ready |=> table_ready)
    else $error("table ready dropped without reset");
endmodule // fqt_query_table_props

bind fqt_query_table fqt_query_table_props chk_u (
  .core_clk   (core_clk),
  .nrst       (nrst),
  .query_mode (query_mode),
  .req        (req),
  .rsp        (rsp),
  .table_ready(table_ready)
);

// ---- bench/fqt_host_model.sv ----
module fqt_host_model
  import fqt_pkg::*;
(
  input  wire logic     core_clk,
  input  wire fqt_rsp_t rsp,
  output logic          query_mode,
  output fqt_req_t      req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle host, not yet in query mode
  initial begin
    query_mode = 1'b0;
    req        = '0;
  end

  // One word read; mode chooses query mode or array mode
  task automatic rd(input logic [26:0] a, input logic mode, output logic got, output logic [15:0] d,
                    output logic h);
    @(posedge core_clk);
    query_mode <= mode;
    req        <= '{valid: 1'b1, addr: a};
    @(posedge core_clk);
    req.valid <= 1'b0;
    req.addr  <= ~a;    // Released address shows garbage
    #1;
    got = rsp.valid;
    d   = rsp.data;
    h   = rsp.hit;
  endtask
endmodule // fqt_host_model

// ---- bench/tb_top.sv ----
module tb_top
  import fqt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic     core_clk;    // 40 MHz clock
  logic     nrst;        // Active low reset
  logic     query_mode;  // From host model
  fqt_req_t req;         // From host model
  fqt_rsp_t rsp;         // Answer of the 1Gb top table
  fqt_rsp_t rsp_bot;     // Answer of the 512Mb bottom table
  fqt_rsp_t rsp_sym;     // Answer of the 2Gb symmetrical table
  logic     table_ready; // Loader done
  logic     ready_bot;   // Loader done, bottom table
  logic     ready_sym;   // Loader done, symmetrical table
  int       errors;      // Mismatch count
  int       checks;      // Comparison count
  logic     got;         // Answer strobe seen
  logic     hit;         // Hit flag seen
  logic [15:0] dat;      // Answer data seen
  // Expected tables, offsets 1Bh to 38h: 1Gb top, 512Mb bottom, 2Gb symmetrical
  logic [7:0] exp_tab [0:29] = '{8'h23, 8'h36, 8'h85, 8'h95, 8'h09, 8'h0A, 8'h0A, 8'h00, 8'h01, 8'h02,
                                 8'h02, 8'h00, 8'h1B, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h02, 8'hFE, 8'h03,
                                 8'h00, 8'h02, 8'h03, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] exp_bot [0:29] = '{8'h23, 8'h36, 8'h85, 8'h95, 8'h09, 8'h0A, 8'h0A, 8'h00, 8'h01, 8'h02,
                                 8'h02, 8'h00, 8'h1A, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h02, 8'h03, 8'h00,
                                 8'h80, 8'h00, 8'hFE, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] exp_sym [0:29] = '{8'h23, 8'h36, 8'h85, 8'h95, 8'h09, 8'h0A, 8'h0A, 8'h00, 8'h01, 8'h02,
                                 8'h02, 8'h00, 8'h1B, 8'h01, 8'h00, 8'h0A, 8'h00, 8'h01, 8'hFF, 8'h03,
                                 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  fqt_query_table #(.density(FQT_DENS_1G), .layout(FQT_LAY_TOP)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .query_mode(query_mode), .req(req), .rsp(rsp),
    .table_ready(table_ready));
  // Two more variants answer the same reads
  fqt_query_table #(.density(FQT_DENS_512M), .layout(FQT_LAY_BOTTOM)) dut_bot_u (
    .core_clk(core_clk), .nrst(nrst), .query_mode(query_mode), .req(req), .rsp(rsp_bot),
    .table_ready(ready_bot));
  fqt_query_table #(.density(FQT_DENS_2G), .layout(FQT_LAY_SYM)) dut_sym_u (
    .core_clk(core_clk), .nrst(nrst), .query_mode(query_mode), .req(req), .rsp(rsp_sym),
    .table_ready(ready_sym));
  fqt_host_model host_u (.core_clk(core_clk), .rsp(rsp), .query_mode(query_mode), .req(req));

  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait for the loader
  task automatic wait_ready();
    for (int n = 0; n < 100 && table_ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check("table_ready", {15'h0, table_ready}, 16'h0001);
    check("variant ready", {14'h0, ready_bot, ready_sym}, 16'h0003);
  endtask

  // Reads before loading and outside query mode are ignored
  task automatic t_refused();
    host_u.rd(27'h1B, 1'b1, got, dat, hit);
    check("early read", {15'h0, got}, 16'h0000);
    wait_ready();
    host_u.rd(27'h1B, 1'b0, got, dat, hit);
    check("array mode read", {15'h0, got}, 16'h0000);
    check("array mode data", {hit, dat[14:0]}, 16'h0000);
  endtask

  // Whole table, word by word, in all three variants
  task automatic t_sweep();
    for (int i = 0; i < 30; i++) begin
      host_u.rd(27'h1B + 27'(i), 1'b1, got, dat, hit);
      check("sweep valid", {14'h0, got, hit}, 16'h0003);
      check("sweep data", dat, {8'h00, exp_tab[i]});
      check("bottom data", rsp_bot.data, {8'h00, exp_bot[i]});
      check("sym data", rsp_sym.data, {8'h00, exp_sym[i]});
      check("variant valid", {14'h0, rsp_bot.valid, rsp_sym.valid}, 16'h0003);
    end
  endtask

  // Addresses outside the table answer zero
  task automatic t_miss();
    logic [26:0] a [4] = '{27'h10, 27'h1A, 27'h39, 27'h400001B};
    foreach (a[i]) begin
      host_u.rd(a[i], 1'b1, got, dat, hit);
      check("miss flags", {14'h0, got, hit}, 16'h0002);
      check("miss data", dat, 16'h0000);
    end
  endtask

  // Reset in mid-run clears and reloads the table
  task automatic t_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    #1;
    check("reset ready", {15'h0, table_ready}, 16'h0000);
    check("reset data", rsp.data, 16'h0000);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    wait_ready();
    host_u.rd(27'h27, 1'b1, got, dat, hit);
    check("capacity", dat, 16'h001B);
    check("bottom capacity", rsp_bot.data, 16'h001A);
  endtask

  // Main sequence
  initial begin
    errors = 0;
    checks = 0;
    nrst   = 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    t_refused();
    t_sweep();
    t_miss();
    t_reset();
    close_out();
  end

  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    close_out();
  end
endmodule // tb_top
